/* File: sapc_host.sv */
// Purpose: host model driving start, clocks and serial readout
// Assumes: tasks are called from the bench
// Notes: both clocks stand still outside frames
`timescale 1ns/100ps
module sapc_host (
    input wire logic clock, // system clock
    input wire logic data_in, // resolved data line
    output logic start_n = 1'b1, // start pin
    output logic ext_clk = 1'b0, // external clock
    output logic comp = 1'b0, // comparator decision
    output logic shift_clk = 1'b1, // shift clock, idles high
    output logic read_n = 1'b1 // read pin
);
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    // one conversion; twice adds a start edge in mid-conversion
    task automatic convert(input logic [13:0] pat, input logic ext, input logic twice);
        if (!ext) begin
            ext_clk <= 1'b1; // static high selects the internal clock
            comp <= pat[13];
            cyc(220);
        end
        start_n <= 1'b0;
        cyc(4);
        for (int i = 0; i < 16; i++) begin
            start_n <= !(twice && i == 4); // early release
            ext_clk <= !ext; // 800 ns clock only inside the frame
            comp <= (i < 14) ? pat[13-i] : 1'b0;
            cyc(4);
            ext_clk <= 1'b1;
            cyc(4);
        end
        ext_clk <= !ext;
        cyc(6); // acquisition gap
    endtask : convert
    // capture just before each falling edge; falling edge advances the bit
    task automatic readout(output logic [13:0] got);
        read_n <= 1'b0;
        cyc(6);
        for (int i = 13; i >= 0; i--) begin
            got[i] = data_in;
            shift_clk <= 1'b0;
            cyc(6);
            shift_clk <= 1'b1;
            cyc(6);
        end
        read_n <= 1'b1;
    endtask : readout
    // read level is set before power down
    task automatic set_read(input logic v);
        read_n <= v;
        cyc(4);
    endtask : set_read
endmodule : sapc_host

/* File: sapc_pkg.sv */
// Purpose: shared constants and types for the converter control block
// Assumes: 10 MHz system clock, 14-bit result
// Notes: all pin inputs travel together as one packed bundle
package sapc_pkg;

    localparam int RES_W = 14;
    localparam int IDX_W = 4;
    localparam logic [IDX_W-1:0] MSB_IDX = 4'h000D;
    localparam logic [IDX_W-1:0] LSB_IDX = 4'h0000;
    localparam logic [IDX_W-1:0] SHIFT_LEN = 4'h000E;

    // timing: system clock period and the longest external clock high time
    localparam int CLK_PERIOD_NS = 100;
    localparam int EXT_HIGH_MAX_NS = 20000;
    localparam int EXT_IDLE_CYC = EXT_HIGH_MAX_NS / CLK_PERIOD_NS;
    localparam int IDLE_W = 8;
    localparam logic [IDLE_W-1:0] EXT_IDLE_LIM = IDLE_W'(EXT_IDLE_CYC);

    // register bus
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h0000;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 4'h0004;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 4'h0008;
    localparam logic [ADDR_W-1:0] ADDR_RESULT = 4'h000C;

    // sticky event bits
    localparam int EV_W = 3;
    localparam int EV_DONE = 0;
    localparam int EV_IGNORED = 1;
    localparam int EV_WAKE = 2;
    localparam logic [EV_W-1:0] MASK_RESET = 3'h0000;

    // reset values of the pin-facing flops
    localparam logic [RES_W-1:0] RES_ZERO = 14'h0000;
    localparam logic BUSY_IDLE = 1'b1;

    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DOWN} sapc_state_t;

    // pin bundle passed through the synchroniser
    typedef struct packed {
        logic start_n;
        logic power_down_n;
        logic read_n;
        logic ext_clk;
        logic shift_clk;
        logic comp;
    } sapc_pins_t;

    localparam int PINS_W = $bits(sapc_pins_t);
    localparam sapc_pins_t PINS_IDLE = 6'h003E;

endpackage : sapc_pkg

/* File: sapc_sync.sv */
// Purpose: two-flop synchroniser for a bundle of asynchronous pins
// Assumes: every bit is an independent level
// Notes: the first stage is read only by the second stage
`timescale 1ns/100ps
module sapc_sync (
    input wire logic clock, // system clock
    input wire logic sys_rst, // async reset, active high
    input wire sapc_pkg::sapc_pins_t pins_in, // raw pin levels
    output sapc_pkg::sapc_pins_t pins_out // synchronised levels
);
    import sapc_pkg::*;

    logic [PINS_W-1:0] stage1_q;
    logic [PINS_W-1:0] stage2_q;

    // one synchroniser per pin bit
    genvar gi;
    generate
        for (gi = 0; gi < PINS_W; gi++) begin : g_bit
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    stage1_q[gi] <= PINS_IDLE[gi];
                    stage2_q[gi] <= PINS_IDLE[gi];
                end else begin
                    stage1_q[gi] <= pins_in[gi];
                    stage2_q[gi] <= stage1_q[gi];
                end
            end
        end
    endgenerate

    assign pins_out = stage2_q;

endmodule : sapc_sync

/* File: sapc_top.sv */
// Purpose: control and serial readout of a 14-bit successive-approximation converter
// Assumes: all pins asynchronous to clock; comparator decision arrives on comp_in
// Notes: shift and conversion clocks are sampled, so they must stay well below 5 MHz
//
// Functional notes
// - falling conversion start begins a conversion
// - busy low during conversion, high otherwise
// - start edges ignored while converting
// - bit-decision register cleared at conversion start
// - resolve fourteen bits, MSB down to LSB
// - external clock held high selects internal clock
// - active conversion clock mirrored on output pin
// - result shifted out serially on shift clock
// - data driven only while read is low
// - power down while power-down input low
// - read level at power-down picks light or deep
// - output updates after falling shift clock edge
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/100ps
module sapc_top (
    input wire logic clock, // system clock, 10 MHz
    input wire logic sys_rst, // async reset, active high
    input wire logic conversion_start_n, // start pin, falling edge starts
    input wire logic power_down_n, // shutdown pin, low = power down
    input wire logic read_n, // read pin, low enables data output
    input wire logic ext_conv_clock_in, // external conversion clock or static high
    input wire logic shift_clock, // host shift clock
    input wire logic comp_in, // comparator decision, high keeps the trial bit
    input wire logic [sapc_pkg::ADDR_W-1:0] reg_addr, // register address
    input wire logic [sapc_pkg::DATA_W-1:0] reg_wdata, // register write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [sapc_pkg::DATA_W-1:0] reg_rdata, // read data, cycle after strobe
    output logic busy_n, // low while converting
    output logic conv_clock_out, // conversion clock in use
    output logic data_out, // serial result bit
    output logic data_oe, // high while data_out is driven
    output logic [sapc_pkg::RES_W-1:0] dac_code, // code steering the capacitive DAC
    output logic low_power, // high in power down
    output logic irq // level interrupt
);
    import sapc_pkg::*;

    // raw pins, their synchronised levels and the previous synchronised sample
    sapc_pins_t raw_pins;
    sapc_pins_t pins_s;
    sapc_pins_t prev_q;

    assign raw_pins = '{start_n: conversion_start_n, power_down_n: power_down_n,
                        read_n: read_n, ext_clk: ext_conv_clock_in,
                        shift_clk: shift_clock, comp: comp_in};

    // every pin passes two flops before any logic reads it
    sapc_sync u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .pins_in(raw_pins),
        .pins_out(pins_s)
    );

    // edge detection on synchronised pins only
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prev_q <= PINS_IDLE;
        end else begin
            prev_q <= pins_s;
        end
    end

    // one-cycle edge strobes, built only from synchronised levels
    logic start_fall;
    logic sclk_fall;
    logic ext_rise;
    assign start_fall = prev_q.start_n & ~pins_s.start_n;
    assign sclk_fall = prev_q.shift_clk & ~pins_s.shift_clk;
    assign ext_rise = ~prev_q.ext_clk & pins_s.ext_clk;

    // conversion clock selection and internal divider
    logic [IDLE_W-1:0] idle_cnt_q, idle_cnt_d;
    logic int_clk_q, int_clk_d;
    logic conv_clk_q, conv_clk_d;
    logic ext_mode;
    logic conv_tick;
    logic sleep_q, sleep_d;
    sapc_state_t state_q, state_d;

    // a static high longer than the longest legal high phase means internal mode
    assign ext_mode = (idle_cnt_q < EXT_IDLE_LIM);
    assign conv_tick = ext_mode ? ext_rise : (int_clk_d & ~int_clk_q);

    // next values of the ext-idle counter and both conversion clocks
    always_comb begin
        idle_cnt_d = idle_cnt_q;
        if (!pins_s.ext_clk) begin
            idle_cnt_d = '0;
        end else if (idle_cnt_q < EXT_IDLE_LIM) begin
            idle_cnt_d = idle_cnt_q + 1'b1;
        end
        // deep shutdown stops the internal oscillator, light keeps it running
        int_clk_d = (state_q == ST_DOWN && sleep_q) ? 1'b0 : ~int_clk_q;
        conv_clk_d = ext_mode ? pins_s.ext_clk : int_clk_d;
    end

    // clock selection registers; reset starts in internal mode
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            idle_cnt_q <= EXT_IDLE_LIM;
            int_clk_q <= 1'b0;
            conv_clk_q <= 1'b0;
        end else begin
            idle_cnt_q <= idle_cnt_d;
            int_clk_q <= int_clk_d;
            conv_clk_q <= conv_clk_d;
        end
    end

    // conversion sequencer
    logic [RES_W-1:0] bdr_q, bdr_d;
    logic [RES_W-1:0] result_q, result_d;
    logic [IDX_W-1:0] idx_q, idx_d;
    logic busy_n_q, busy_n_d;
    logic [EV_W-1:0] ev_set;
    logic low_power_q, low_power_d;

    // next state of the conversion sequencer
    always_comb begin
        state_d = state_q;
        bdr_d = bdr_q;
        result_d = result_q;
        idx_d = idx_q;
        busy_n_d = busy_n_q;
        sleep_d = sleep_q;
        ev_set = '0;
        unique case (state_q)
            ST_IDLE: begin
                if (!pins_s.power_down_n) begin
                    state_d = ST_DOWN;
                    sleep_d = pins_s.read_n;
                end else if (start_fall) begin
                    state_d = ST_CONV;
                    bdr_d = RES_ZERO;
                    bdr_d[MSB_IDX] = 1'b1;
                    idx_d = MSB_IDX;
                    busy_n_d = 1'b0;
                end
            end
            ST_CONV: begin
                if (start_fall) begin
                    ev_set[EV_IGNORED] = 1'b1;
                end
                if (!pins_s.power_down_n) begin
                    // shutdown abandons the running conversion
                    state_d = ST_DOWN;
                    sleep_d = pins_s.read_n;
                    busy_n_d = BUSY_IDLE;
                end else if (conv_tick) begin
                    if (!pins_s.comp) begin
                        bdr_d[idx_q] = 1'b0;
                    end
                    if (idx_q == LSB_IDX) begin
                        state_d = ST_IDLE;
                        result_d = bdr_d;
                        busy_n_d = BUSY_IDLE;
                        ev_set[EV_DONE] = 1'b1;
                    end else begin
                        idx_d = idx_q - 1'b1;
                        bdr_d[idx_d] = 1'b1;
                    end
                end
            end
            ST_DOWN: begin
                if (pins_s.power_down_n) begin
                    state_d = ST_IDLE;
                    ev_set[EV_WAKE] = 1'b1;
                end
            end
            default: begin
                // an illegal state code falls back to idle with busy released
                state_d = ST_IDLE;
                busy_n_d = BUSY_IDLE;
            end
        endcase
        low_power_d = (state_d == ST_DOWN);
    end

    // sequencer registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            bdr_q <= RES_ZERO;
            result_q <= RES_ZERO;
            idx_q <= MSB_IDX;
            busy_n_q <= BUSY_IDLE;
            sleep_q <= 1'b0;
            low_power_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bdr_q <= bdr_d;
            result_q <= result_d;
            idx_q <= idx_d;
            busy_n_q <= busy_n_d;
            sleep_q <= sleep_d;
            low_power_q <= low_power_d;
        end
    end

    // serial readout, loaded at the end of each conversion
    logic [RES_W-1:0] shift_q, shift_d;
    logic [IDX_W-1:0] sent_q, sent_d;
    logic dout_q, dout_d;
    logic doe_q, doe_d;

    // next shift state; a load at conversion end outranks a shift
    always_comb begin
        shift_d = shift_q;
        sent_d = sent_q;
        if (ev_set[EV_DONE]) begin
            shift_d = result_d;
            sent_d = '0;
        end else if (sclk_fall && !pins_s.read_n && sent_q < SHIFT_LEN) begin
            shift_d = {shift_q[RES_W-2:0], 1'b0};
            sent_d = sent_q + 1'b1;
        end
        // data_out moves one edge after a detected fall, never before it
        dout_d = shift_d[MSB_IDX];
        doe_d = ~pins_s.read_n;
    end

    // readout registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            shift_q <= RES_ZERO;
            sent_q <= SHIFT_LEN;
            dout_q <= 1'b0;
            doe_q <= 1'b0;
        end else begin
            shift_q <= shift_d;
            sent_q <= sent_d;
            dout_q <= dout_d;
            doe_q <= doe_d;
        end
    end

    // register file: sticky status cleared by reading it, set wins over clear
    logic [EV_W-1:0] status_q, status_d;
    logic [EV_W-1:0] mask_q, mask_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic irq_q, irq_d;

    // next register file contents and read data
    always_comb begin
        status_d = status_q;
        mask_d = mask_q;
        rdata_d = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_STATUS: begin
                    rdata_d = DATA_W'(status_q);
                    status_d = '0;
                end
                ADDR_MASK: rdata_d = DATA_W'(mask_q);
                ADDR_STATE: rdata_d = DATA_W'({sleep_q, state_q == ST_DOWN,
                                              ext_mode, ~busy_n_q});
                ADDR_RESULT: rdata_d = DATA_W'(result_q);
                default: rdata_d = '0;
            endcase
        end
        if (reg_wr && reg_addr == ADDR_MASK) begin
            mask_d = reg_wdata[EV_W-1:0];
        end
        // set wins: an event in the read cycle survives the clear
        status_d = status_d | ev_set;
        irq_d = |(status_d & mask_d);
    end

    // register file registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            status_q <= '0;
            mask_q <= MASK_RESET;
            rdata_q <= '0;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    // outputs straight from flops
    assign reg_rdata = rdata_q;
    assign busy_n = busy_n_q;
    assign conv_clock_out = conv_clk_q;
    assign data_out = dout_q;
    assign data_oe = doe_q;
    assign dac_code = bdr_q;
    assign low_power = low_power_q;
    assign irq = irq_q;

endmodule : sapc_top

/* File: sapc_top_asserts.sv */
// Purpose: concurrent checks on the converter control pins
// Assumes: pins reach the logic through a two-flop synchroniser
// Notes: the bind to sapc_top follows the module
`timescale 1ns/100ps
module sapc_top_asserts (
    input wire logic clock, // clock
    input wire logic sys_rst, // reset
    input wire logic conversion_start_n, // pin
    input wire logic power_down_n, // pin
    input wire logic read_n, // pin
    input wire logic ext_conv_clock_in, // pin
    input wire logic shift_clock, // pin
    input wire logic busy_n, // output
    input wire logic conv_clock_out, // output
    input wire logic data_out, // output
    input wire logic data_oe, // output
    input wire logic [sapc_pkg::RES_W-1:0] dac_code, // output
    input wire logic low_power // output
);
    import sapc_pkg::*;
    logic [8:0] low_q, low_d, hi_q, hi_d;
    // busy-low length and static-high run of the external clock
    always_comb begin
        low_d = busy_n ? 9'h000 : low_q + 9'h001;
        hi_d = !ext_conv_clock_in ? 9'h000 : (&hi_q ? hi_q : hi_q + 9'h001);
    end
    // registers only; saturation keeps long idle runs from wrapping
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            low_q <= 9'h000;
            hi_q <= 9'h000;
        end else begin
            low_q <= low_d;
            hi_q <= hi_d;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    start_busy_a: assert property (
        $fell(conversion_start_n) && busy_n && !low_power |-> ##[3:5] !busy_n
    ) else $error("start edge gave no busy");
    busy_len_a: assert property (
        $rose(busy_n) && !low_power |-> low_q >= 9'h01a
    ) else $error("conversion too short");
    clear_bdr_a: assert property (
        $fell(busy_n) |-> ##[0:1] dac_code == 14'h2000
    ) else $error("decision register not cleared");
    ext_mirror_a: assert property (
        $rose(ext_conv_clock_in) && !busy_n |-> ##[2:4] conv_clock_out
    ) else $error("external clock not mirrored");
    int_clock_a: assert property (
        hi_q > 9'h0d2 && !busy_n && !low_power |-> conv_clock_out != $past(conv_clock_out)
    ) else $error("internal clock not running");
    data_oe_a: assert property (
        read_n [*4] |-> !data_oe
    ) else $error("data driven without read");
    pd_enter_a: assert property (
        !power_down_n [*5] |-> low_power
    ) else $error("no power down");
    shift_hold_a: assert property (
        $fell(shift_clock) && busy_n |-> $stable(data_out) [*3]
    ) else $error("data moved before shift edge");
    cover property ($rose(busy_n));
    cover property (!busy_n && $fell(conversion_start_n));
    cover property ($rose(low_power));
endmodule : sapc_top_asserts

bind sapc_top sapc_top_asserts u_sapc_chk (
    .clock(clock), .sys_rst(sys_rst), .conversion_start_n(conversion_start_n),
    .power_down_n(power_down_n), .read_n(read_n), .ext_conv_clock_in(ext_conv_clock_in),
    .shift_clock(shift_clock), .busy_n(busy_n), .conv_clock_out(conv_clock_out),
    .data_out(data_out), .data_oe(data_oe), .dac_code(dac_code), .low_power(low_power)
);

/* File: sar_adc_control_serial_readout_tb_top.sv */
// Purpose: self-checking bench for the converter control block
// Assumes: host model drives the pins, bench drives power down and registers
// Notes: the data line floats when not enabled
`timescale 1ns/100ps
module sar_adc_control_serial_readout_tb_top;
    import sapc_pkg::*;
    logic clock, sys_rst, power_down_n, reg_wr, reg_rd;
    logic start_n, ext_clk, comp, shift_clk, read_n;
    logic busy_n, conv_clock_out, data_out, data_oe, low_power, irq;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [RES_W-1:0] dac_code, got;
    int fails, total_checks;
    wire dline = data_oe ? data_out : 1'bz;
    sapc_top u_dut (
        .clock(clock), .sys_rst(sys_rst), .conversion_start_n(start_n),
        .power_down_n(power_down_n), .read_n(read_n), .ext_conv_clock_in(ext_clk),
        .shift_clock(shift_clk), .comp_in(comp), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy_n(busy_n),
        .conv_clock_out(conv_clock_out), .data_out(data_out), .data_oe(data_oe),
        .dac_code(dac_code), .low_power(low_power), .irq(irq)
    );
    sapc_host u_host (
        .clock(clock), .data_in(dline), .start_n(start_n), .ext_clk(ext_clk),
        .comp(comp), .shift_clk(shift_clk), .read_n(read_n)
    );
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rc(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        chk(n, e, reg_rdata);
        @(posedge clock);
    endtask : rc
    task automatic t_reset();
        chk("busy_n", 16'h0001, 16'(busy_n));
        chk("data_oe", 16'h0000, 16'(data_oe));
        rc("mask", ADDR_MASK, 16'h0000);
        rc("unmapped", 4'h2, 16'h0000);
    endtask : t_reset
    // external clock, restart attempt, serial readout, done interrupt
    task automatic t_ext();
        wr(ADDR_MASK, 16'h0003);
        u_host.convert(14'h2a5c, 1'b1, 1'b1);
        chk("busy_n", 16'h0001, 16'(busy_n));
        chk("irq", 16'h0001, 16'(irq));
        rc("result", ADDR_RESULT, 16'h2a5c);
        rc("state", ADDR_STATE, 16'h0002);
        u_host.readout(got);
        chk("serial", 16'h2a5c, 16'(got));
        rc("status", ADDR_STATUS, 16'h0003);
        repeat (2) @(posedge clock);
        chk("irq", 16'h0000, 16'(irq));
    endtask : t_ext
    // internal clock with the done event masked
    task automatic t_int();
        wr(ADDR_MASK, 16'h0000);
        u_host.convert(14'h3fff, 1'b0, 1'b0);
        rc("result", ADDR_RESULT, 16'h3fff);
        rc("state", ADDR_STATE, 16'h0000);
        chk("irq", 16'h0000, 16'(irq));
        rc("status", ADDR_STATUS, 16'h0001);
    endtask : t_int
    // deep then light power down, wake event unmasked late
    task automatic t_pd();
        power_down_n <= 1'b0;
        repeat (6) @(posedge clock);
        chk("low_power", 16'h0001, 16'(low_power));
        rc("state", ADDR_STATE, 16'h000c);
        power_down_n <= 1'b1;
        u_host.set_read(1'b0);
        power_down_n <= 1'b0;
        repeat (6) @(posedge clock);
        rc("state", ADDR_STATE, 16'h0004);
        chk("data_oe", 16'h0001, 16'(data_oe));
        power_down_n <= 1'b1;
        u_host.set_read(1'b1);
        repeat (6) @(posedge clock); // wake gap
        chk("low_power", 16'h0000, 16'(low_power));
        chk("irq", 16'h0000, 16'(irq));
        wr(ADDR_MASK, 16'h0004);
        repeat (2) @(posedge clock);
        chk("irq", 16'h0001, 16'(irq));
        rc("status", ADDR_STATUS, 16'h0004);
    endtask : t_pd
    task automatic end_sim();
        if (fails == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        sys_rst = 1'b1;
        power_down_n = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        fails = 0;
        total_checks = 0;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clock);
        t_reset();
        t_ext();
        t_int();
        t_pd();
        end_sim();
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        end_sim();
    end
endmodule : sar_adc_control_serial_readout_tb_top
